// ---- oib_ctl_model.sv ----
// outside scan controller model driving the four-wire test port
`timescale 1ns/100ps
module oib_ctl_model (
	// test port
	output logic tck,
	output logic tms_o,
	output logic tms_oe,
	output logic tdi,
	// serial answer, already resolved with its pull-up
	input wire logic tdo
);
	// tck stands low between frames, as a real controller would leave it
	initial begin
		tck = 1'b0;
		tms_o = 1'b1;
		tms_oe = 1'b1;
		tdi = 1'b1;
	end

	// one test clock; levels change on the fall, so setup and hold are half a period
	task automatic step(input logic m, input logic d, output logic o);
		tms_o = m;
		tdi = d;
		#62.5 o = tdo;
		tck = 1'b1;
		#62.5 tck = 1'b0;
	endtask : step

	// full scan from idle back to idle, lsb first; tdi released high outside shifts
	task automatic scan(input logic ir, input int n, input logic [17:0] din,
		output logic [17:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : scan

	// five clocks with mode select high, driven or left floating
	task automatic reset_walk(input logic drive);
		logic o;
		tms_oe = drive;
		repeat (5) step(1'b1, 1'b1, o);
		tms_oe = 1'b1;
	endtask : reset_walk
endmodule : oib_ctl_model

// ---- oib_defs.svh ----
// constants for the octal inverting buffer with scan tap
`ifndef OIB_DEFS_SVH
`define OIB_DEFS_SVH
`define OIB_IR_W 8
`define OIB_BSR_W 18
`define OIB_BCR_W 2
`define OIB_IR_BYPASS 8'hff
`define OIB_IR_CAPTURE 8'h81
`define OIB_IR_EXTEST 8'h00
`define OIB_IR_SAMPLE 8'h01
`define OIB_IR_READ_HOLD 8'h02
`define OIB_IR_RUN_TEST 8'h03
`define OIB_BCR_RST 2'h2
`define OIB_BCR_COMPACT 2'h2
`define OIB_BCR_PATTERN 2'h1
`define OIB_BSR_OE_LSB 0
`define OIB_BSR_A_LSB 2
`define OIB_BSR_Y_LSB 10
`define OIB_BSR_RST 18'h00003
`define OIB_LFSR_TAPS 8'h1d
`define OIB_LFSR_SEED 8'h01
`define OIB_TAP_RESET_CLKS 5
`define OIB_SYNC_W 14
`define OIB_SYNC_RST 14'h1fff
`endif

// ---- oib_pkg.sv ----
// types shared by the buffer and scan tap files
`include "oib_defs.svh"
package oib_pkg;
	typedef enum logic [3:0] {
		OIB_TLR, OIB_RTI, OIB_SEL_DR, OIB_CAP_DR, OIB_SH_DR, OIB_EX1_DR, OIB_PA_DR,
		OIB_EX2_DR, OIB_UPD_DR, OIB_SEL_IR, OIB_CAP_IR, OIB_SH_IR, OIB_EX1_IR,
		OIB_PA_IR, OIB_EX2_IR, OIB_UPD_IR
	} oib_tap_state_e;

	typedef struct packed {
		logic second_group_enable_low;
		logic first_group_enable_low;
		logic [7:0] data;
	} oib_pins_s;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe;
	} oib_drive_s;

	// galois step, data folded in after the shift
	function automatic logic [7:0] oib_lfsr_step(input logic [7:0] s, input logic [7:0] d);
		logic [7:0] n;
		n = {s[6:0], 1'b0} ^ (s[7] ? `OIB_LFSR_TAPS : 8'h00);
		return n ^ d;
	endfunction : oib_lfsr_step
endpackage : oib_pkg

// ---- oib_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module oib_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// meta_r feeds only q; nothing else may look at it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= RST;
			q <= RST;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : oib_sync

// ---- oib_tap_fsm.sv ----
// sixteen state test port controller
`timescale 1ns/100ps
module oib_tap_fsm (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// steering
	input wire logic tck_rise,
	input wire logic tms,
	input wire logic test_reset,
	// state
	output oib_pkg::oib_tap_state_e state_r
);
	import oib_pkg::*;
	oib_tap_state_e state_nxt;
	logic [2:0] hi_cnt_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			OIB_TLR: state_nxt = tms ? OIB_TLR : OIB_RTI;
			OIB_RTI: state_nxt = tms ? OIB_SEL_DR : OIB_RTI;
			OIB_SEL_DR: state_nxt = tms ? OIB_SEL_IR : OIB_CAP_DR;
			OIB_CAP_DR: state_nxt = tms ? OIB_EX1_DR : OIB_SH_DR;
			OIB_SH_DR: state_nxt = tms ? OIB_EX1_DR : OIB_SH_DR;
			OIB_EX1_DR: state_nxt = tms ? OIB_UPD_DR : OIB_PA_DR;
			OIB_PA_DR: state_nxt = tms ? OIB_EX2_DR : OIB_PA_DR;
			OIB_EX2_DR: state_nxt = tms ? OIB_UPD_DR : OIB_SH_DR;
			OIB_UPD_DR: state_nxt = tms ? OIB_SEL_DR : OIB_RTI;
			OIB_SEL_IR: state_nxt = tms ? OIB_TLR : OIB_CAP_IR;
			OIB_CAP_IR: state_nxt = tms ? OIB_EX1_IR : OIB_SH_IR;
			OIB_SH_IR: state_nxt = tms ? OIB_EX1_IR : OIB_SH_IR;
			OIB_EX1_IR: state_nxt = tms ? OIB_UPD_IR : OIB_PA_IR;
			OIB_PA_IR: state_nxt = tms ? OIB_EX2_IR : OIB_PA_IR;
			OIB_EX2_IR: state_nxt = tms ? OIB_UPD_IR : OIB_SH_IR;
			OIB_UPD_IR: state_nxt = tms ? OIB_SEL_DR : OIB_RTI;
		endcase
	end

	// double high level acts at once, without waiting for a test clock edge
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= OIB_TLR;
		end else if (test_reset) begin
			state_r <= OIB_TLR;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end

	// counts consecutive rising edges seen with tms high, cleared by one with tms low, saturating at 7
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt_r <= 3'h0;
		end else if (tck_rise) begin
			hi_cnt_r <= !tms ? 3'h0 : (hi_cnt_r == 3'h7 ? hi_cnt_r : hi_cnt_r + 3'h1);
		end
	end

	a_reset_in_five: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hi_cnt_r >= 3'(`OIB_TAP_RESET_CLKS) |-> state_r == OIB_TLR)
		else $error("tap not in reset after five high clocks");
	a_dh_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
		test_reset |=> state_r == OIB_TLR)
		else $error("double high level did not reset the tap");
endmodule : oib_tap_fsm

// ---- oib_tap_top.sv ----
// octal inverting tri-state buffer wrapped by a boundary scan test port
`timescale 1ns/100ps
`include "oib_defs.svh"
module oib_tap_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// buffer pins
	input wire oib_pkg::oib_pins_s buf_in,
	output oib_pkg::oib_drive_s buf_drive_r,
	// test port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic double_high_reset_level,
	output logic tdo_r,
	output logic tdo_oe_r
);
	import oib_pkg::*;

	logic [`OIB_SYNC_W-1:0] pin_raw;
	logic [`OIB_SYNC_W-1:0] pin_s;
	logic dh_s;
	logic tdi_s;
	logic tms_s;
	logic tck_s;
	logic [1:0] oe_low_s;
	logic [7:0] a_s;
	logic tck_q_r;
	logic tck_rise;
	logic tck_fall;
	oib_tap_state_e state;
	logic [`OIB_IR_W-1:0] ir_sh_r;
	logic [`OIB_IR_W-1:0] ir_r;
	logic [`OIB_BSR_W-1:0] bsr_sh_r;
	logic [`OIB_BSR_W-1:0] bsr_upd_r;
	logic [`OIB_BCR_W-1:0] bcr_sh_r;
	logic [`OIB_BCR_W-1:0] bcr_r;
	logic bypass_r;
	logic sel_bsr;
	logic sel_bcr;
	logic in_test;
	logic dr_lsb;
	logic input_signature_compactor_run;
	logic output_pattern_generator_run;

	// pins are asynchronous; pull-up levels are the synchroniser reset values
	assign pin_raw = {double_high_reset_level, tdi, tms, tck, buf_in.second_group_enable_low,
		buf_in.first_group_enable_low, buf_in.data};
	assign {dh_s, tdi_s, tms_s, tck_s, oe_low_s, a_s} = pin_s;

	oib_sync #(.W(`OIB_SYNC_W), .RST(`OIB_SYNC_RST)) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.d(pin_raw),
		.q(pin_s)
	);

	// test clock edges found by sampling; tck must stay well below sys_clk / 4
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tck_q_r <= 1'b1;
		end else begin
			tck_q_r <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_q_r;
	assign tck_fall = ~tck_s & tck_q_r;

	oib_tap_fsm u_fsm (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tck_rise(tck_rise),
		.tms(tms_s),
		.test_reset(dh_s),
		.state_r(state)
	);

	// instruction decode
	assign sel_bsr = (ir_r == `OIB_IR_EXTEST) || (ir_r == `OIB_IR_SAMPLE) ||
		(ir_r == `OIB_IR_READ_HOLD);
	assign sel_bcr = (ir_r == `OIB_IR_RUN_TEST);
	assign in_test = (ir_r == `OIB_IR_EXTEST) || (ir_r == `OIB_IR_RUN_TEST);
	assign input_signature_compactor_run = sel_bcr && state == OIB_RTI && tck_rise &&
		bcr_r == `OIB_BCR_COMPACT;
	assign output_pattern_generator_run = sel_bcr && state == OIB_RTI && tck_rise &&
		bcr_r == `OIB_BCR_PATTERN;
	assign dr_lsb = sel_bsr ? bsr_sh_r[0] : (sel_bcr ? bcr_sh_r[0] : bypass_r);

	// instruction register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ir_sh_r <= `OIB_IR_CAPTURE;
			ir_r <= `OIB_IR_BYPASS;
		end else if (state == OIB_TLR) begin
			ir_r <= `OIB_IR_BYPASS;
		end else begin
			if (tck_rise && state == OIB_CAP_IR) begin
				ir_sh_r <= `OIB_IR_CAPTURE;
			end else if (tck_rise && state == OIB_SH_IR) begin
				ir_sh_r <= {tdi_s, ir_sh_r[`OIB_IR_W-1:1]};
			end
			if (tck_fall && state == OIB_UPD_IR) begin
				ir_r <= ir_sh_r;
			end
		end
	end

	// boundary shift stage
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bsr_sh_r <= `OIB_BSR_RST;
		end else if (tck_rise && sel_bsr && state == OIB_CAP_DR) begin
			if (ir_r == `OIB_IR_READ_HOLD) begin
				bsr_sh_r <= bsr_upd_r;
			end else begin
				bsr_sh_r <= {buf_drive_r.level, a_s, oe_low_s};
			end
		end else if (tck_rise && sel_bsr && state == OIB_SH_DR) begin
			bsr_sh_r <= {tdi_s, bsr_sh_r[`OIB_BSR_W-1:1]};
		end
	end

	// boundary hold stage; compaction and pattern run here so a read back sees them
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bsr_upd_r <= `OIB_BSR_RST;
		end else if (tck_fall && sel_bsr && state == OIB_UPD_DR) begin
			bsr_upd_r <= bsr_sh_r;
		end else if (input_signature_compactor_run) begin
			bsr_upd_r[`OIB_BSR_A_LSB +: 8] <= oib_lfsr_step(bsr_upd_r[`OIB_BSR_A_LSB +: 8],
				a_s);
		end else if (output_pattern_generator_run) begin
			// an all-zero seed would lock the generator, so it is kicked with the seed
			bsr_upd_r[`OIB_BSR_Y_LSB +: 8] <= (bsr_upd_r[`OIB_BSR_Y_LSB +: 8] == 8'h00) ?
				`OIB_LFSR_SEED : oib_lfsr_step(bsr_upd_r[`OIB_BSR_Y_LSB +: 8], 8'h00);
		end
	end

	// boundary control register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bcr_sh_r <= `OIB_BCR_RST;
			bcr_r <= `OIB_BCR_RST;
		end else if (state == OIB_TLR) begin
			bcr_r <= `OIB_BCR_RST;
		end else begin
			if (tck_rise && sel_bcr && state == OIB_CAP_DR) begin
				bcr_sh_r <= bcr_r;
			end else if (tck_rise && sel_bcr && state == OIB_SH_DR) begin
				bcr_sh_r <= {tdi_s, bcr_sh_r[`OIB_BCR_W-1:1]};
			end
			if (tck_fall && sel_bcr && state == OIB_UPD_DR) begin
				bcr_r <= bcr_sh_r;
			end
		end
	end

	// bypass register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bypass_r <= 1'b0;
		end else if (tck_rise && !sel_bsr && !sel_bcr && state == OIB_CAP_DR) begin
			bypass_r <= 1'b0;
		end else if (tck_rise && !sel_bsr && !sel_bcr && state == OIB_SH_DR) begin
			bypass_r <= tdi_s;
		end
	end

	// serial output changes only on the falling edge, or at once on the double high level
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tdo_r <= 1'b1;
			tdo_oe_r <= 1'b0;
		end else if (dh_s) begin
			// the double high level has no test clock to wait for, so the pin goes off at once
			tdo_r <= 1'b1;
			tdo_oe_r <= 1'b0;
		end else if (tck_fall) begin
			if (state == OIB_SH_IR) begin
				tdo_r <= ir_sh_r[0];
				tdo_oe_r <= 1'b1;
			end else if (state == OIB_SH_DR) begin
				tdo_r <= dr_lsb;
				tdo_oe_r <= 1'b1;
			end else begin
				tdo_r <= 1'b1;
				tdo_oe_r <= 1'b0;
			end
		end
	end

	// buffer outputs; two cycles of synchroniser latency from the pins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_drive_r <= '0;
		end else if (in_test) begin
			buf_drive_r.level <= bsr_upd_r[`OIB_BSR_Y_LSB +: 8];
			buf_drive_r.oe <= {{4{~bsr_upd_r[`OIB_BSR_OE_LSB + 1]}},
				{4{~bsr_upd_r[`OIB_BSR_OE_LSB]}}};
		end else begin
			buf_drive_r.level <= ~a_s;
			buf_drive_r.oe <= {{4{~oe_low_s[1]}}, {4{~oe_low_s[0]}}};
		end
	end

	a_group_hiz: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!in_test && oe_low_s[0]) |=> buf_drive_r.oe[3:0] == 4'h0)
		else $error("disabled group still drives");
	a_invert_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!in_test && !oe_low_s[1]) |=>
		(buf_drive_r.oe[7:4] == 4'hf && buf_drive_r.level[7:4] == ~$past(a_s[7:4])))
		else $error("enabled group does not invert");
	a_normal_untouched: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!in_test && state != OIB_TLR) |=> buf_drive_r.level == ~$past(a_s))
		else $error("tap activity disturbed normal buffers");
	a_test_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
		in_test |=> buf_drive_r.level == $past(bsr_upd_r[`OIB_BSR_Y_LSB +: 8]))
		else $error("test mode outputs not from boundary cells");
	a_tdo_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
		($changed(tdo_r) || $changed(tdo_oe_r)) |-> ($past(tck_fall) || $past(dh_s)))
		else $error("serial output moved off a falling edge");
	a_ir_shift_in: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_rise && state == OIB_SH_IR) |=>
		(ir_sh_r == {$past(tdi_s), $past(ir_sh_r[`OIB_IR_W-1:1])}))
		else $error("instruction shift did not take serial input");
	a_tdo_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!tdo_oe_r |-> tdo_r)
		else $error("serial output low while undriven");
	a_tms_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(rst_b) |-> tms_s)
		else $error("mode select not high out of reset");
	a_compact_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		input_signature_compactor_run |=> bsr_upd_r[`OIB_BSR_A_LSB +: 8] ==
		oib_lfsr_step($past(bsr_upd_r[`OIB_BSR_A_LSB +: 8]), $past(a_s)))
		else $error("signature step wrong");
	a_ir_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_rise && state == OIB_CAP_IR) |=> ir_sh_r == `OIB_IR_CAPTURE)
		else $error("instruction capture value wrong");
	a_tlr_defaults: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state == OIB_TLR |=> (ir_r == `OIB_IR_BYPASS && bcr_r == `OIB_BCR_COMPACT))
		else $error("tap reset defaults wrong");
	a_group2_hiz: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!in_test && oe_low_s[1]) |=> buf_drive_r.oe[7:4] == 4'h0)
		else $error("disabled second group still drives");
	a_invert_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!in_test && !oe_low_s[0]) |=>
		(buf_drive_r.oe[3:0] == 4'hf && buf_drive_r.level[3:0] == ~$past(a_s[3:0])))
		else $error("enabled first group does not invert");
	a_test_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
		in_test |=> buf_drive_r.oe == {{4{~$past(bsr_upd_r[`OIB_BSR_OE_LSB + 1])}},
		{4{~$past(bsr_upd_r[`OIB_BSR_OE_LSB])}}})
		else $error("test mode enables not from boundary cells");
	a_dr_shift_in: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_rise && sel_bsr && state == OIB_SH_DR) |=>
		(bsr_sh_r == {$past(tdi_s), $past(bsr_sh_r[`OIB_BSR_W-1:1])}))
		else $error("boundary shift did not take serial input");
	a_dr_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_rise && sel_bsr && ir_r != `OIB_IR_READ_HOLD && state == OIB_CAP_DR) |=>
		bsr_sh_r == {$past(buf_drive_r.level), $past(a_s), $past(oe_low_s)})
		else $error("boundary capture order wrong");
	a_tdo_shift_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_fall && !dh_s && state == OIB_SH_IR) |=> (tdo_oe_r && tdo_r == $past(ir_sh_r[0])))
		else $error("serial output not showing instruction lsb");
	a_dh_tdo_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		dh_s |=> !tdo_oe_r)
		else $error("serial output still driven after double high");
	a_bypass_shift: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(tck_rise && !sel_bsr && !sel_bcr && state == OIB_SH_DR) |=> bypass_r == $past(tdi_s))
		else $error("bypass bit did not take serial input");
	a_pattern_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		output_pattern_generator_run |=> bsr_upd_r[`OIB_BSR_Y_LSB +: 8] ==
		(($past(bsr_upd_r[`OIB_BSR_Y_LSB +: 8]) == 8'h00) ? `OIB_LFSR_SEED :
		oib_lfsr_step($past(bsr_upd_r[`OIB_BSR_Y_LSB +: 8]), 8'h00)))
		else $error("pattern step wrong");

	c_ir_update: cover property (@(posedge sys_clk) disable iff (!rst_b)
		tck_fall && state == OIB_UPD_IR);
	c_extest: cover property (@(posedge sys_clk) disable iff (!rst_b)
		ir_r == `OIB_IR_EXTEST && tdo_oe_r);
	c_compact: cover property (@(posedge sys_clk) disable iff (!rst_b)
		input_signature_compactor_run);
	c_pattern: cover property (@(posedge sys_clk) disable iff (!rst_b)
		output_pattern_generator_run);
	c_dh_reset: cover property (@(posedge sys_clk) disable iff (!rst_b)
		dh_s && tdo_oe_r);
endmodule : oib_tap_top

// ---- oib_tap_top_tb.sv ----
// self-checking bench for the inverting buffer with scan tap
`timescale 1ns/100ps
`include "oib_defs.svh"
module oib_tap_top_tb;
	import oib_pkg::*;
	logic sys_clk;
	logic rst_b;
	oib_pins_s buf_in;
	oib_drive_s buf_drive_r;
	logic tck;
	logic tms_o;
	logic tms_oe;
	logic tdi;
	logic double_high_reset_level;
	logic tdo_r;
	logic tdo_oe_r;
	logic seen;
	logic [17:0] cap;
	int err_total = 0;
	int check_count = 0;
	// pull-ups on mode select and serial out
	wire logic tms_pin = tms_oe ? tms_o : 1'b1;
	wire logic tdo_pin = tdo_oe_r ? tdo_r : 1'b1;

	oib_tap_top uut (
		.sys_clk(sys_clk), .rst_b(rst_b), .buf_in(buf_in), .buf_drive_r(buf_drive_r),
		.tck(tck), .tms(tms_pin), .tdi(tdi),
		.double_high_reset_level(double_high_reset_level),
		.tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r)
	);
	oib_ctl_model ctl (
		.tck(tck), .tms_o(tms_o), .tms_oe(tms_oe), .tdi(tdi), .tdo(tdo_pin)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test();
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// pins need two sync flops plus the output flop, so five edges is ample
	task automatic pins(input logic [1:0] en, input logic [7:0] d);
		@(posedge sys_clk) #1;
		buf_in = {en, d};
		repeat (5) @(posedge sys_clk);
		#1;
	endtask : pins

	function automatic logic [17:0] norm(input logic [1:0] en, input logic [7:0] d);
		return 18'({~d, {4{~en[1]}}, {4{~en[0]}}});
	endfunction : norm

	function automatic logic [7:0] nxt(input logic [7:0] s, input logic [7:0] d);
		return ({s[6:0], 1'b0} ^ (s[7] ? 8'h1d : 8'h00)) ^ d;
	endfunction : nxt

	task automatic ir(input logic [7:0] c);
		ctl.scan(1'b1, 8, {10'h0, c}, cap);
	endtask : ir

	task automatic dr(input int n, input logic [17:0] v);
		ctl.scan(1'b0, n, v, cap);
	endtask : dr

	task automatic idle(input int k);
		repeat (k) ctl.step(1'b0, 1'b1, seen);
	endtask : idle

	task automatic t_normal();
		logic [7:0] dv [4];
		dv = '{8'h00, 8'hff, 8'ha5, 8'h3c};
		for (int e = 0; e < 4; e++)
			for (int i = 0; i < 4; i++) begin
				pins(2'(e), dv[i]);
				check(18'(buf_drive_r), norm(2'(e), dv[i]));
			end
	endtask : t_normal

	task automatic t_bypass();
		ctl.reset_walk(1'b1);
		idle(1);
		check(18'({tdo_oe_r, tdo_r}), 18'h1);
		dr(8, 18'hb5);
		check(cap, 18'h6a);
		ir(`OIB_IR_SAMPLE);
		check(cap, 18'h81);
	endtask : t_bypass

	// sampling while buffers run; the shifted word becomes the preload
	task automatic t_sample();
		pins(2'b01, 8'hc3);
		dr(18, {8'h5a, 8'h00, 2'b10});
		check(cap, {8'h3c, 8'hc3, 2'b01});
		pins(2'b10, 8'h0f);
		check(18'(buf_drive_r), norm(2'b10, 8'h0f));
	endtask : t_sample

	task automatic t_extest();
		ir(`OIB_IR_EXTEST);
		check(18'(buf_drive_r), {2'h0, 8'h5a, 8'h0f});
		pins(2'b01, 8'h33);
		check(18'(buf_drive_r), {2'h0, 8'h5a, 8'h0f});
		pins(2'b10, 8'h0f);
		dr(18, {8'h5a, 8'h00, 2'b10});
		check(cap, {8'h5a, 8'h0f, 2'b10});
	endtask : t_extest

	// double high in mid shift, with no test clock at all
	task automatic t_dh();
		ctl.step(1'b1, 1'b1, seen);
		idle(2);
		repeat (6) @(posedge sys_clk);
		#1;
		check(18'(tdo_oe_r), 18'h1);
		double_high_reset_level = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 double_high_reset_level = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		check(18'(buf_drive_r), norm(2'b10, 8'h0f));
		check(18'(tdo_oe_r), 18'h0);
	endtask : t_dh

	// shift-dr is the far end: five floating clocks must still land in reset
	task automatic t_float();
		ctl.reset_walk(1'b1);
		idle(1);
		ir(`OIB_IR_EXTEST);
		pins(2'b11, 8'hff);
		check(18'(buf_drive_r), {2'h0, 8'h5a, 8'h0f});
		ctl.step(1'b1, 1'b1, seen);
		idle(2);
		ctl.reset_walk(1'b0);
		check(18'(buf_drive_r), norm(2'b11, 8'hff));
		idle(1);
	endtask : t_float

	task automatic t_sig();
		logic [7:0] sig;
		logic [7:0] pat;
		sig = 8'h00;
		pat = 8'h00;
		repeat (5) sig = nxt(sig, 8'h96);
		repeat (10) pat = (pat == 8'h00) ? 8'h01 : nxt(pat, 8'h00);
		ir(`OIB_IR_SAMPLE);
		dr(18, 18'h0);
		pins(2'b00, 8'h96);
		ir(`OIB_IR_RUN_TEST);
		check(18'(buf_drive_r), 18'h000ff);
		idle(4);
		ir(`OIB_IR_READ_HOLD);
		dr(18, 18'h0);
		check(18'(cap[9:2]), 18'(sig));
		pins(2'b00, 8'h00);
		ir(`OIB_IR_RUN_TEST);
		dr(2, 18'h1);
		idle(10);
		check(18'(buf_drive_r), {2'h0, pat, 8'hff});
	endtask : t_sig

	initial begin
		buf_in = {2'b00, 8'h00};
		double_high_reset_level = 1'b0;
		rst_b = 1'b0;
		repeat (5) @(posedge sys_clk);
		check(18'({buf_drive_r, tdo_oe_r}), 18'h0);
		#1 rst_b = 1'b1;
		repeat (5) @(posedge sys_clk);
		t_normal();
		t_bypass();
		t_sample();
		t_extest();
		t_dh();
		t_float();
		t_sig();
		finish_test();
	end

	// the whole run needs about 32 us of test clocks
	initial begin
		#200000;
		err_total++;
		finish_test();
	end
endmodule : oib_tap_top_tb
